// file: logic/nbt_flash_dev.sv
// Flash end: power-up command gating and busy timing of a serial NAND.
// Assumes CLK_IN is free running and SCK only toggles inside frames.
// Summary of operation
// - No command taken during first lockout window.
// - Then only status read and reset taken.
// - Busy flag set during power-up initialisation.
// - After full-ready time, all commands taken while idle; only status read and reset while busy.
// - Host waits power-on time before relying.
// - Program clears busy within maximum program time.
// - Host limits partial programs per page.
// - Normal array read busy within maximum.
// - Fast read mode shortens array read busy.
// - Reset during read recovers within limit.
// - Reset during program recovers within limit.
// - Reset during erase recovers within limit.
// - Protect busy shorter than maximum program.
// - Fast read enable defaults to one.
`timescale 1ns/10ps
module nbt_flash_dev
    import nbt_pkg::*;
#(
    parameter int LOCK_CYC      = T_LOCKOUT_NS / CLK_PERIOD_NS,
    parameter int INIT_CYC      = T_ALL_OPS_NS / CLK_PERIOD_NS,
    parameter int PROG_CYC      = T_PROG_NS / CLK_PERIOD_NS,
    parameter int PROTECT_CYC   = T_PROTECT_NS / CLK_PERIOD_NS,
    parameter int READ_CYC      = T_READ_NS / CLK_PERIOD_NS,
    parameter int FAST_READ_CYC = T_FAST_READ_NS / CLK_PERIOD_NS,
    parameter int ERASE_CYC     = T_ERASE_NS / CLK_PERIOD_NS,
    parameter int RST_READ_CYC  = T_RST_READ_NS / CLK_PERIOD_NS,
    parameter int RST_PROG_CYC  = T_RST_PROG_NS / CLK_PERIOD_NS,
    parameter int RST_ERASE_CYC = T_RST_ERASE_NS / CLK_PERIOD_NS,
    parameter int RST_IDLE_CYC  = T_RST_IDLE_NS / CLK_PERIOD_NS
)(
    input  wire logic CLK_IN,
    input  wire logic SRST_IN,
    nbt_link_if.dev   LINK,
    output logic      BUSY_OUT,
    output logic      ALL_OPS_OUT,
    output logic      FAST_READ_OUT
);

    // Protect time must stay under the longest program time.
    if (PROTECT_CYC >= T_PROG_MAX_NS / CLK_PERIOD_NS || LOCK_CYC < 1 || INIT_CYC <= LOCK_CYC
        || FAST_READ_CYC < 1 || RST_IDLE_CYC < 1)
    begin : g_bad_par
        $error("nbt_flash_dev: unusable timing parameters.");
    end

    // System clock domain state.
    typedef struct packed {
        logic        link_rst;
        logic [31:0] pwr_cnt;
        logic        lock_done;
        logic        init_done;
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_seen;
        logic        busy;
        logic [31:0] bcnt;
        nbt_kind_t   kind;
        logic        fast;
        logic        flag;
    } nbt_core_t;

    // Frame state, cleared whenever chip select rises.
    typedef struct packed {
        logic [5:0]  cnt;
        logic [30:0] inw;
        logic [7:0]  op;
        logic        acc;
        logic        rd;
        logic [7:0]  osh;
        logic        miso;
    } nbt_frame_t;

    // Link state that outlives a frame.
    typedef struct packed {
        logic        tog;
        logic [7:0]  op;
        logic [15:0] arg;
        logic        lock_s1;
        logic        lock_s2;
        logic        init_s1;
        logic        init_s2;
        logic        bsy_s1;
        logic        bsy_s2;
        logic        fast_s1;
        logic        fast_s2;
    } nbt_keep_t;

    localparam nbt_core_t CORE_RST = '{link_rst: 1'b1, kind: K_IDLE, fast: FAST_RESET,
                                       flag: 1'b1, default: '0};

    nbt_core_t  c;
    nbt_core_t  next_c;
    nbt_frame_t f;
    nbt_frame_t next_f;
    nbt_keep_t  p;
    nbt_keep_t  next_p;

    // Which commands the link may take in the current power and busy phase.
    function automatic logic cmd_ok(input logic [7:0] op, input logic lk, input logic ini, input logic bsy);
        logic sts;
        sts = (op == OP_GET_FEAT) || (op == OP_RESET) || (op == OP_RESET_ALT);
        if (!lk)
            return 1'b0;
        else if (!ini || bsy)
            return sts;
        else
            return 1'b1;
    endfunction : cmd_ok

    // Feature byte seen by a status read at the given address.
    function automatic logic [7:0] feat_byte(input logic [7:0] adr, input logic bsy, input logic fst);
        logic [7:0] b;
        b = 8'h00;
        if (adr == FEAT_STATUS_ADDR)
            b[OIP_POS] = bsy;
        else if (adr == FEAT_CFG_ADDR)
            b[FAST_POS] = fst;
        return b;
    endfunction : feat_byte

    // Next state of the system clock domain: power-up windows and busy timer.
    always_comb
    begin
        next_c          = c;
        next_c.link_rst = 1'b0;
        next_c.tog_s1   = p.tog;
        next_c.tog_s2   = c.tog_s1;
        if (c.pwr_cnt < 32'(INIT_CYC))
            next_c.pwr_cnt = c.pwr_cnt + 32'h1;
        next_c.lock_done = (c.pwr_cnt >= 32'(LOCK_CYC));
        next_c.init_done = (c.pwr_cnt >= 32'(INIT_CYC));
        if (c.busy)
        begin
            if (c.bcnt <= 32'h1)
            begin
                next_c.busy = 1'b0;
                next_c.kind = K_IDLE;
            end
            else
                next_c.bcnt = c.bcnt - 32'h1;
        end
        // The link holds op and arg still until the toggle has been seen here.
        if (c.tog_s2 != c.tog_seen)
        begin
            next_c.tog_seen = c.tog_s2;
            if (p.op == OP_RESET || p.op == OP_RESET_ALT)
            begin
                next_c.busy = c.init_done;
                next_c.kind = K_IDLE;
                case (c.kind)
                    K_READ:  next_c.bcnt = 32'(RST_READ_CYC);
                    K_PROG:  next_c.bcnt = 32'(RST_PROG_CYC);
                    K_ERASE: next_c.bcnt = 32'(RST_ERASE_CYC);
                    default: next_c.bcnt = 32'(RST_IDLE_CYC);
                endcase
            end
            else if (c.init_done && !c.busy)
            begin
                next_c.busy = (p.op != OP_SET_FEAT);
                case (p.op)
                    OP_SET_FEAT:
                    begin
                        if (p.arg[15:8] == FEAT_CFG_ADDR)
                            next_c.fast = p.arg[FAST_POS];
                    end
                    OP_ARRAY_RD:
                    begin
                        next_c.kind = K_READ;
                        next_c.bcnt = c.fast ? 32'(FAST_READ_CYC) : 32'(READ_CYC);
                    end
                    OP_PROG_EXE:
                    begin
                        next_c.kind = K_PROG;
                        next_c.bcnt = 32'(PROG_CYC);
                    end
                    OP_PROTECT:
                    begin
                        next_c.kind = K_PROG;
                        next_c.bcnt = 32'(PROTECT_CYC);
                    end
                    OP_ERASE:
                    begin
                        next_c.kind = K_ERASE;
                        next_c.bcnt = 32'(ERASE_CYC);
                    end
                    default: next_c.busy = 1'b0;
                endcase
            end
        end
        next_c.flag = next_c.busy | ~next_c.init_done;
    end

    // System clock registers; fast read enable comes up set.
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            c <= CORE_RST;
        else
            c <= next_c;
    end

    // Next frame state: shift in mosi, decode opcode, rotate status out.
    always_comb
    begin
        logic [7:0] cur;
        cur        = {f.inw[6:0], LINK.mosi};
        next_f     = f;
        next_f.inw = {f.inw[29:0], LINK.mosi};
        if (f.cnt != BIT_SAT)
            next_f.cnt = f.cnt + 6'h1;
        if (f.cnt == LAST_BIT_B0)
        begin
            next_f.op  = cur;
            next_f.acc = cmd_ok(cur, p.lock_s2, p.init_s2, p.bsy_s2);
        end
        // Status output repeats the same byte for as long as the frame lasts.
        if (f.cnt == LAST_BIT_B1 && f.acc && f.op == OP_GET_FEAT)
        begin
            next_f.rd   = 1'b1;
            next_f.osh  = feat_byte(cur, p.bsy_s2, p.fast_s2);
            next_f.miso = next_f.osh[7];
            next_f.osh  = {next_f.osh[6:0], next_f.osh[7]};
        end
        else if (f.rd)
        begin
            next_f.miso = f.osh[7];
            next_f.osh  = {f.osh[6:0], f.osh[7]};
        end
    end

    // Frame registers, cleared by chip select so no edge after the frame is needed.
    always_ff @(posedge LINK.sck or posedge LINK.cs_n)
    begin
        if (LINK.cs_n)
            f <= '0;
        else
            f <= next_f;
    end

    // Next long-lived link state: event toggle and level synchronisers.
    always_comb
    begin
        logic [7:0] cur;
        logic       fire;
        cur          = {f.inw[6:0], LINK.mosi};
        fire = (f.cnt == LAST_BIT_B0 && (cur == OP_RESET || cur == OP_RESET_ALT)
                && cmd_ok(cur, p.lock_s2, p.init_s2, p.bsy_s2))
            || (f.cnt == LAST_BIT_B2 && f.acc && f.op == OP_SET_FEAT)
            || (f.cnt == LAST_BIT_B3 && f.acc && (f.op == OP_ARRAY_RD || f.op == OP_PROG_EXE
                || f.op == OP_PROTECT || f.op == OP_ERASE));
        next_p       = p;
        next_p.lock_s1 = c.lock_done;
        next_p.lock_s2 = p.lock_s1;
        next_p.init_s1 = c.init_done;
        next_p.init_s2 = p.init_s1;
        next_p.bsy_s1  = c.flag;
        next_p.bsy_s2  = p.bsy_s1;
        next_p.fast_s1 = c.fast;
        next_p.fast_s2 = p.fast_s1;
        if (fire)
        begin
            next_p.tog = ~p.tog;
            next_p.op  = (f.cnt == LAST_BIT_B0) ? cur : f.op;
            next_p.arg = {f.inw[14:0], LINK.mosi};
        end
    end

    // Link registers, cleared only by the system reset.
    always_ff @(posedge LINK.sck or posedge c.link_rst)
    begin
        if (c.link_rst)
            p <= '0;
        else
            p <= next_p;
    end

    assign LINK.miso     = f.miso;
    assign BUSY_OUT      = c.flag;
    assign ALL_OPS_OUT   = c.init_done;
    assign FAST_READ_OUT = c.fast;

endmodule : nbt_flash_dev

// file: logic/nbt_flash_host.sv
// Host end: issues flash commands over the serial link and keeps host timing.
// Assumes SRST_IN marks supply coming up; SCK is divided down from CLK_IN.
`timescale 1ns/10ps
module nbt_flash_host
    import nbt_pkg::*;
#(
    parameter int HALF_CYC = 4,
    parameter int LOCK_CYC = (T_LOCKOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int WAIT_CYC = (T_ALL_OPS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)(
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    nbt_link_if.host         LINK,
    input  wire logic        REQ_IN,
    input  wire logic [7:0]  OP_IN,
    input  wire logic [23:0] ARG_IN,
    output logic             READY_OUT,
    output logic             DONE_OUT,
    output logic             REFUSED_OUT,
    output logic [7:0]       RDATA_OUT,
    output logic             ALL_OPS_OUT
);

    localparam int CSH_CYC = (T_CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Half periods under four cycles leave no margin for the miso synchroniser.
    // Windows may be shortened for short runs; the default full-ready wait covers the power-on wait.
    if (HALF_CYC < 4 || HALF_CYC > 255 || LOCK_CYC < 1 || LOCK_CYC >= WAIT_CYC
        || T_ALL_OPS_NS < T_PWR_WAIT_NS)
    begin : g_bad_par
        $error("nbt_flash_host: unusable timing parameters.");
    end

    typedef struct packed {
        nbt_hstate_t st;
        logic [31:0] pwr_cnt;
        logic        lock_done;
        logic        all_ok;
        logic [7:0]  div;
        logic [5:0]  bitc;
        logic [5:0]  nbits;
        logic [31:0] tx;
        logic [7:0]  op;
        logic [7:0]  rx;
        logic        sck;
        logic        cs_n;
        logic        mosi;
        logic        miso_s1;
        logic        miso_s2;
        logic [16:0] last_row;
        logic [2:0]  pp_cnt;
        logic        ready;
        logic        done;
        logic        refused;
        logic [7:0]  rdata;
    } nbt_host_t;

    localparam nbt_host_t HOST_RST = '{st: H_IDLE, cs_n: 1'b1, default: '0};

    nbt_host_t h;
    nbt_host_t next_h;

    // Next host state: power windows, command filter and frame sequencing.
    always_comb
    begin
        logic sts;
        logic rowop;
        logic same;
        sts   = (OP_IN == OP_GET_FEAT) || (OP_IN == OP_RESET) || (OP_IN == OP_RESET_ALT);
        rowop = (OP_IN == OP_ARRAY_RD) || (OP_IN == OP_PROG_EXE) || (OP_IN == OP_PROTECT) || (OP_IN == OP_ERASE);
        same  = (ARG_IN[16:0] == h.last_row);
        next_h         = h;
        next_h.miso_s1 = LINK.miso;
        next_h.miso_s2 = h.miso_s1;
        next_h.done    = 1'b0;
        next_h.refused = 1'b0;
        if (h.pwr_cnt < 32'(WAIT_CYC))
            next_h.pwr_cnt = h.pwr_cnt + 32'h1;
        next_h.lock_done = (h.pwr_cnt >= 32'(LOCK_CYC));
        next_h.all_ok    = (h.pwr_cnt >= 32'(WAIT_CYC));
        case (h.st)
            H_IDLE:
            begin
                if (REQ_IN)
                begin
                    if (!h.lock_done || (!h.all_ok && !sts)
                        || !(sts || rowop || OP_IN == OP_SET_FEAT || OP_IN == OP_WR_EN || OP_IN == OP_WR_DIS)
                        || (OP_IN == OP_PROG_EXE && same && h.pp_cnt >= 3'(PARTIAL_PROG_MAX)))
                        next_h.refused = 1'b1;
                    else
                    begin
                        if (OP_IN == OP_PROG_EXE)
                        begin
                            next_h.last_row = ARG_IN[16:0];
                            next_h.pp_cnt   = same ? h.pp_cnt + 3'h1 : 3'h1;
                        end
                        next_h.st    = H_RUN;
                        next_h.op    = OP_IN;
                        next_h.tx    = {OP_IN, ARG_IN};
                        next_h.mosi  = OP_IN[7];
                        next_h.cs_n  = 1'b0;
                        next_h.div   = 8'h00;
                        next_h.bitc  = 6'h00;
                        next_h.rx    = 8'h00;
                        next_h.nbits = rowop ? LAST_BIT_B3 + 6'h1
                                     : (OP_IN == OP_GET_FEAT || OP_IN == OP_SET_FEAT) ? LAST_BIT_B2 + 6'h1
                                     : LAST_BIT_B0 + 6'h1;
                    end
                end
            end
            H_RUN:
            begin
                next_h.div = h.div + 8'h1;
                if (h.div == 8'(HALF_CYC - 1))
                begin
                    next_h.div = 8'h00;
                    next_h.sck = ~h.sck;
                    if (!h.sck)
                    begin
                        // Status bits are taken just before each rising edge of the third byte.
                        next_h.bitc = h.bitc + 6'h1;
                        if (h.op == OP_GET_FEAT && h.bitc > LAST_BIT_B1)
                            next_h.rx = {h.rx[6:0], h.miso_s2};
                    end
                    else if (h.bitc == h.nbits)
                    begin
                        next_h.st    = H_GAP;
                        next_h.cs_n  = 1'b1;
                        next_h.mosi  = 1'b0;
                        next_h.done  = 1'b1;
                        next_h.rdata = h.rx;
                    end
                    else
                    begin
                        next_h.tx   = {h.tx[30:0], 1'b0};
                        next_h.mosi = h.tx[30];
                    end
                end
            end
            H_GAP:
            begin
                // Keeps chip select high for the least deselect time.
                next_h.div = h.div + 8'h1;
                if (h.div == 8'(CSH_CYC - 1))
                begin
                    next_h.div = 8'h00;
                    next_h.st  = H_IDLE;
                end
            end
            default: next_h.st = H_IDLE;
        endcase
        next_h.ready = (next_h.st == H_IDLE);
    end

    // Host registers.
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            h <= HOST_RST;
        else
            h <= next_h;
    end

    assign LINK.sck    = h.sck;
    assign LINK.cs_n   = h.cs_n;
    assign LINK.mosi   = h.mosi;
    assign READY_OUT   = h.ready;
    assign DONE_OUT    = h.done;
    assign REFUSED_OUT = h.refused;
    assign RDATA_OUT   = h.rdata;
    assign ALL_OPS_OUT = h.all_ok;

endmodule : nbt_flash_host

// file: logic/nbt_link_if.sv
// Serial link between the flash model and its host controller.
// Assumes the host drives the clock and select; the device drives only miso.
`timescale 1ns/10ps
interface nbt_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    modport dev  (input sck, input cs_n, input mosi, output miso);
    modport host (output sck, output cs_n, output mosi, input miso);
endinterface : nbt_link_if

// file: logic/nbt_pkg.sv
// Shared constants for the serial NAND busy-timing model and its host.
// Assumes one system clock of CLK_PERIOD_NS and an SPI mode 0 link.
package nbt_pkg;
    // System clock period.
    localparam int CLK_PERIOD_NS  = 4;
    // Power-up windows.
    localparam int T_LOCKOUT_NS   = 100_000;
    localparam int T_ALL_OPS_NS   = 1_100_000;
    localparam int T_PWR_WAIT_NS  = 1_000_000;
    // Array operation busy times.
    localparam int T_PROG_NS      = 360_000;
    localparam int T_PROG_MAX_NS  = 500_000;
    localparam int T_PROTECT_NS   = 300_000;
    localparam int T_READ_NS      = 70_000;
    localparam int T_FAST_READ_NS = 30_000;
    localparam int T_ERASE_NS     = 2_700_000;
    // Reset recovery times by interrupted operation.
    localparam int T_RST_READ_NS  = 155_000;
    localparam int T_RST_PROG_NS  = 500_000;
    localparam int T_RST_ERASE_NS = 10_000_000;
    localparam int T_RST_IDLE_NS  = 1_000;
    // Least chip-select high time between frames.
    localparam int T_CS_HIGH_NS   = 100;
    localparam int PARTIAL_PROG_MAX = 4;
    // Command opcodes.
    localparam logic [7:0] OP_GET_FEAT  = 8'h0f;
    localparam logic [7:0] OP_SET_FEAT  = 8'h1f;
    localparam logic [7:0] OP_ARRAY_RD  = 8'h13;
    localparam logic [7:0] OP_PROG_EXE  = 8'h10;
    localparam logic [7:0] OP_PROTECT   = 8'h2a;
    localparam logic [7:0] OP_ERASE     = 8'hd8;
    localparam logic [7:0] OP_RESET     = 8'hff;
    localparam logic [7:0] OP_RESET_ALT = 8'hfe;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    // Feature addresses and bit positions.
    localparam logic [7:0] FEAT_STATUS_ADDR = 8'hc0;
    localparam logic [7:0] FEAT_CFG_ADDR    = 8'hb0;
    localparam int OIP_POS  = 0;
    localparam int FAST_POS = 1;
    localparam logic FAST_RESET = 1'b1;
    // Last bit index of each frame byte, counted from zero.
    localparam logic [5:0] LAST_BIT_B0 = 6'h07;
    localparam logic [5:0] LAST_BIT_B1 = 6'h0f;
    localparam logic [5:0] LAST_BIT_B2 = 6'h17;
    localparam logic [5:0] LAST_BIT_B3 = 6'h1f;
    localparam logic [5:0] BIT_SAT     = 6'h3f;
    // Kind of timed operation in progress.
    typedef enum logic [3:0] {
        K_IDLE  = 4'b0001,
        K_READ  = 4'b0010,
        K_PROG  = 4'b0100,
        K_ERASE = 4'b1000
    } nbt_kind_t;
    // Host sequencer states.
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_RUN  = 3'b010,
        H_GAP  = 3'b100
    } nbt_hstate_t;
endpackage : nbt_pkg

// file: test/nbt_link_assertions.sv
// Checker for the flash busy-timing pair: link wires and the flags of both ends.
// Assumes the bench instantiates it beside the link interface, on the system clock.
`timescale 1ns/10ps
module nbt_link_assertions #(
    parameter int LOCK_CYC = 50,
    parameter int INIT_CYC = 2000,
    parameter int WAIT_CYC = 250000,
    parameter int MAX_BUSY = 2050
)(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic BUSY_OUT,
    input wire logic ALL_OPS_OUT,
    input wire logic FAST_READ_OUT,
    input wire logic READY_OUT,
    input wire logic DONE_OUT,
    input wire logic REFUSED_OUT,
    input wire logic H_ALL_OPS_OUT
);
    logic [19:0] cyc;
    logic [19:0] run;

    // Cycles since reset release and length of the running busy span.
    always_ff @(posedge CLK_IN)
    begin
        cyc <= SRST_IN ? 20'h0 : cyc + 20'h1;
        run <= (SRST_IN || !BUSY_OUT) ? 20'h0 : run + 20'h1; // Cleared in reset so it never starts unknown.
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    // A frame opens with the link clock still low, so mode 0 sampling is kept.
    sequence s_open;
        (!sck) [*2];
    endsequence
    property p_lockout; cyc < LOCK_CYC |-> cs_n; endproperty
    a_lockout: assert property (p_lockout) else $error("frame sent during lockout");
    property p_early; cyc + 4 < INIT_CYC |-> !ALL_OPS_OUT; endproperty
    a_early: assert property (p_early) else $error("all operations open too early");
    property p_init_busy; !ALL_OPS_OUT |-> BUSY_OUT; endproperty
    a_init_busy: assert property (p_init_busy) else $error("no busy during init");
    property p_late; cyc >= INIT_CYC + 4 |-> ALL_OPS_OUT; endproperty
    a_late: assert property (p_late) else $error("all operations not open in time");
    property p_host_wait; H_ALL_OPS_OUT |-> cyc + 2 >= WAIT_CYC; endproperty
    a_host_wait: assert property (p_host_wait) else $error("host waited too little");
    property p_busy_bound; BUSY_OUT |-> run <= MAX_BUSY; endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("busy span too long");
    property p_power_up; $fell(SRST_IN) |-> FAST_READ_OUT && BUSY_OUT && !ALL_OPS_OUT; endproperty
    a_power_up: assert property (p_power_up) else $error("wrong flags after power up");
    property p_refuse; REFUSED_OUT |-> cs_n && !DONE_OUT; endproperty
    a_refuse: assert property (p_refuse) else $error("refused request sent a frame");
    property p_frame; $fell(cs_n) |-> !READY_OUT ##0 s_open; endproperty
    a_frame: assert property (p_frame) else $error("bad frame opening");
    property p_done; DONE_OUT |-> cs_n ##1 !DONE_OUT; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
endmodule : nbt_link_assertions

// file: test/tb.sv
// Bench for the flash busy-timing pair: host and device joined by the link.
// Assumes short device counts; the host wait is cut to just past the device's full-ready count.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module tb;
    import nbt_pkg::*;
    localparam int LK = 50, IN = 2000, WT = 2200, RD = 300, FR = 100, PG = 400, PT = 200;
    localparam int ER = 800, RR = 350, RP = 500, RE = 1000;
    logic clk, srst, req, ready, done, refused, h_all, busy, all_ops, fast, rf;
    logic [7:0] op, rdata;
    logic [23:0] arg;
    int n_errors, cmp_count, run;

    nbt_link_if link ();
    nbt_flash_dev #(.LOCK_CYC(40), .INIT_CYC(IN), .PROG_CYC(PG), .PROTECT_CYC(PT), .READ_CYC(RD),
        .FAST_READ_CYC(FR), .ERASE_CYC(ER), .RST_READ_CYC(RR), .RST_PROG_CYC(RP), .RST_ERASE_CYC(RE),
        .RST_IDLE_CYC(20)) u_nbt_flash_dev (.CLK_IN(clk), .SRST_IN(srst), .LINK(link.dev),
        .BUSY_OUT(busy), .ALL_OPS_OUT(all_ops), .FAST_READ_OUT(fast));
    nbt_flash_host #(.LOCK_CYC(LK), .WAIT_CYC(WT)) u_nbt_flash_host (.CLK_IN(clk), .SRST_IN(srst),
        .LINK(link.host), .REQ_IN(req), .OP_IN(op), .ARG_IN(arg), .READY_OUT(ready), .DONE_OUT(done),
        .REFUSED_OUT(refused), .RDATA_OUT(rdata), .ALL_OPS_OUT(h_all));
    nbt_link_assertions #(.LOCK_CYC(LK), .INIT_CYC(IN), .WAIT_CYC(WT), .MAX_BUSY(IN + 50)) u_chk (
        .CLK_IN(clk), .SRST_IN(srst), .sck(link.sck), .cs_n(link.cs_n), .BUSY_OUT(busy),
        .ALL_OPS_OUT(all_ops), .FAST_READ_OUT(fast), .READY_OUT(ready), .DONE_OUT(done),
        .REFUSED_OUT(refused), .H_ALL_OPS_OUT(h_all));

    // Free-running system clock of 4 ns.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Length of the current busy span, counted independently of the design.
    always @(posedge clk)
        run <= (busy === 1'b1) ? run + 1 : 0;

    task give_verdict;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // Wait for the host to be ready, raise the request for one cycle, then wait for done or refusal.
    task automatic cmd(input logic [7:0] o, input logic [23:0] a, output logic r);
        int n;
        n = 0;
        @(posedge clk);
        while (ready !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        req <= 1'b1;
        op  <= o;
        arg <= a;
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (done !== 1'b1 && refused !== 1'b1 && n < 400);
        r = refused;
        `CHK("answer", 1'b1, done | refused)
    endtask : cmd

    // Wait for busy to end; the span is judged by the caller.
    task automatic idle(output int len, output int n);
        n = 0;
        while (busy !== 1'b1 && n < 8)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        len = run;
    endtask : idle

    task automatic timed(input logic [7:0] o, input logic [23:0] a, input int ex);
        int len, n;
        cmd(o, a, rf);
        idle(len, n);
        `CHK("busy span", 1'b1, (len > ex - 2 && len < ex + 2))
    endtask : timed

    // A reset in mid-operation must replace the remaining time with its recovery time.
    task automatic rst_during(input logic [7:0] o, input int ex);
        int len, n;
        cmd(o, 24'h000006, rf);
        cmd(OP_RESET, 24'h0, rf);
        idle(len, n);
        `CHK("recovery", 1'b1, (n <= ex + 1 && n + 8 > ex))
    endtask : rst_during

    // Power-up windows: nothing taken, then status and reset only, then everything.
    task automatic power_up;
        repeat (2) @(posedge clk);
        `CHK("fast", 1'b1, fast)
        cmd(OP_GET_FEAT, {FEAT_STATUS_ADDR, 16'h0}, rf);
        `CHK("lockout", 1'b1, rf)
        repeat (LK) @(posedge clk);
        cmd(OP_ARRAY_RD, 24'h0, rf);
        `CHK("gated", 1'b1, rf)
        cmd(OP_GET_FEAT, {FEAT_STATUS_ADDR, 16'h0}, rf);
        `CHK("init busy", 1'b1, rdata[OIP_POS])
        cmd(OP_GET_FEAT, {FEAT_CFG_ADDR, 16'h0}, rf);
        `CHK("cfg fast", 1'b1, rdata[FAST_POS])
        cmd(OP_RESET, 24'h0, rf);
        `CHK("reset taken", 1'b0, rf)
        while (h_all !== 1'b1)
            @(posedge clk);
        `CHK("all ops", 1'b1, all_ops)
        `CHK("idle", 1'b0, busy)
    endtask : power_up

    // Clearing the fast read enable must reach the device's flag.
    task automatic fast_off;
        cmd(OP_SET_FEAT, {FEAT_CFG_ADDR, 16'h0}, rf);
        repeat (8) @(posedge clk);
        `CHK("fast off", 1'b0, fast)
    endtask : fast_off

    // Four programs to one row go out; the host refuses the fifth.
    task automatic prog_limit;
        repeat (4) timed(OP_PROG_EXE, 24'h000005, PG);
        cmd(OP_PROG_EXE, 24'h000005, rf);
        `CHK("fifth", 1'b1, rf)
    endtask : prog_limit

    // Cuts a hang short; the span is several times the expected run.
    initial
    begin
        repeat (WT + 30000) @(posedge clk);
        n_errors++;
        give_verdict;
    end

    initial
    begin
        srst = 1'b1;
        req = 1'b0;
        op = 8'h00;
        arg = 24'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        power_up;
        timed(OP_ARRAY_RD, 24'h000001, FR);
        fast_off;
        timed(OP_ARRAY_RD, 24'h000002, RD);
        timed(OP_PROTECT, 24'h000003, PT);
        prog_limit;
        rst_during(OP_ARRAY_RD, RR);
        rst_during(OP_PROG_EXE, RP);
        rst_during(OP_ERASE, RE);
        give_verdict;
    end
endmodule : tb
